// ===== verilog/odl_engine.sv
/*
 * Per-endpoint OAM engine: dual-ended loss measurement carried in continuity
 * frames and one-way delay timestamping, for Down-MEP and Up-MEP placement.
 * Assumes frame events arrive as one-cycle valid strobes synchronous to
 * core_clk_i, at most one frame event per stream per cycle.
 */
// Implementation choices: register access over Avalon-MM and the register addresses.

// Overview of operation
// R1: Non-zero counter field marks a loss frame
// R2: Loss handling only with loss enable set
// R3: Insert-next adds forward and backward counters
// R4: Period setting spaces counter-carrying frames
// R5: Down rx loss frame: local count to header
// R6: Optional PDU overwrite with local count
// R7: Backward counters held until next sent
// R8: Up-MEP sends no automatic backward counters
// R9: Up-MEP CPU frames get transmit count inserted
// R10: Up ingress: bump sequence, copy, forward
// R11: Egress captures count and sequence field
// R12: Valid bit, sticky on overwrite
// R13: Five-bit delay sequence sampled into header
// R14: Latest delay sequence kept, bumps per PDU
// R15: Sequence in header bits 31:27, shared
// R16: One-way handling only with delay enable
// R17: Down transmit timestamp at port exit
// R18: Down receive timestamp to PDU or header
// R19: Up transmit timestamp from CPU arrival
// R20: Up ingress copy carries current sequence
// R21: Egress writes timestamp queue entry
// R22: Sequence counters wrap silently
module odl_engine #(
    parameter logic [7:0] ENGINE_NUM = 8'h00
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [odl_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [31:0] tx_loss_counter_i,
    input wire logic [31:0] rx_loss_counter_i,
    input wire logic [31:0] time_now_i,
    input wire odl_pkg::odl_cc_rx_t cc_rx_i,
    input wire logic cc_egress_i,
    input wire odl_pkg::odl_cc_tx_req_t cc_tx_req_i,
    input wire odl_pkg::odl_dm_rx_t dm_rx_i,
    input wire odl_pkg::odl_dm_egr_t dm_egress_i,
    input wire odl_pkg::odl_dm_tx_req_t dm_tx_req_i,
    output odl_pkg::odl_cc_tx_t cc_tx_o,
    output odl_pkg::odl_word_t extract_o,
    output odl_pkg::odl_word_t pdu_update_o,
    output odl_pkg::odl_word_t dm_tx_timestamp_o,
    output odl_pkg::odl_tsq_t tsq_write_o,
    output logic egress_forward_o
);

    // ====================
    // Helpers
    // Any non-zero counter field means the frame carries loss data
    function automatic logic is_loss_frame(input odl_pkg::odl_cc_rx_t f);
        is_loss_frame = (f.txfcf != odl_pkg::ZERO_WORD) || (f.rxfcb != odl_pkg::ZERO_WORD)
            || (f.txfcb != odl_pkg::ZERO_WORD); // R1
    endfunction : is_loss_frame

    // Byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        lane_merge = r;
    endfunction : lane_merge

    // ====================
    // State
    logic [odl_pkg::CTRL_W-1:0] ctrl, next_ctrl;
    logic [odl_pkg::PERIOD_W-1:0] period, next_period;
    logic [odl_pkg::PERIOD_W-1:0] period_cnt, next_period_cnt;
    logic sample_valid, next_sample_valid;
    logic sample_sticky, next_sample_sticky;
    logic [31:0] capture, next_capture;
    logic [odl_pkg::SEQ_W-1:0] lm_seq, next_lm_seq;
    logic [odl_pkg::SEQ_W-1:0] lm_seq_field, next_lm_seq_field;
    logic [odl_pkg::SEQ_W-1:0] dm_seq, next_dm_seq;
    logic [odl_pkg::SEQ_W-1:0] dm_latest, next_dm_latest;
    logic [31:0] held_rx, next_held_rx;
    logic [31:0] held_txf, next_held_txf;
    logic [31:0] readdata, next_readdata;
    logic waitreq, next_waitreq;
    odl_pkg::odl_cc_tx_t cc_tx, next_cc_tx;
    odl_pkg::odl_word_t extract, next_extract;
    odl_pkg::odl_word_t pdu_upd, next_pdu_upd;
    odl_pkg::odl_word_t dm_ts, next_dm_ts;
    odl_pkg::odl_tsq_t tsq, next_tsq;
    logic egr_fwd, next_egr_fwd;

    // Decoded controls
    logic loss_cc_hw_enable;
    logic one_way_delay_enable;
    logic up_mep;
    logic pdu_local_rx_count_update_enable;
    logic front_port_cpu;
    logic loss_insert_next;
    logic bus_take;
    logic wr_take;

    assign loss_cc_hw_enable = ctrl[odl_pkg::CTRL_LOSS_EN];
    assign one_way_delay_enable = ctrl[odl_pkg::CTRL_DELAY_EN];
    assign up_mep = ctrl[odl_pkg::CTRL_UP_MEP];
    assign pdu_local_rx_count_update_enable = ctrl[odl_pkg::CTRL_PDU_UPD];
    assign front_port_cpu = ctrl[odl_pkg::CTRL_FRONT_CPU];
    assign loss_insert_next = ctrl[odl_pkg::CTRL_INS_NEXT];

    // Request is answered on the cycle waitrequest is low
    assign bus_take = (avs_read_i || avs_write_i) && !waitreq;
    assign wr_take = avs_write_i && !waitreq;

    // ====================
    // Next-state logic
    always_comb begin
        logic period_hit;
        logic cc_loss;
        logic dm_ok;
        logic [31:0] wv;
        period_hit = 1'b0;
        cc_loss = 1'b0;
        dm_ok = 1'b0;
        wv = odl_pkg::ZERO_WORD;
        next_ctrl = ctrl;
        next_period = period;
        next_period_cnt = period_cnt;
        next_sample_valid = sample_valid;
        next_sample_sticky = sample_sticky;
        next_capture = capture;
        next_lm_seq = lm_seq;
        next_lm_seq_field = lm_seq_field;
        next_dm_seq = dm_seq;
        next_dm_latest = dm_latest;
        next_held_rx = held_rx;
        next_held_txf = held_txf;
        next_readdata = readdata;
        next_cc_tx = '0;
        next_extract = '0;
        next_pdu_upd = '0;
        next_dm_ts = '0;
        next_tsq = '0;
        next_egr_fwd = 1'b0;

        // Bus handshake: one wait cycle, then answer with waitrequest low
        next_waitreq = !((avs_read_i || avs_write_i) && waitreq);
        if ((avs_read_i || avs_write_i) && waitreq) begin
            unique case (avs_address_i)
                odl_pkg::OFS_CTRL: next_readdata = 32'(ctrl);
                odl_pkg::OFS_PERIOD: next_readdata = 32'(period);
                odl_pkg::OFS_STATUS: begin
                    next_readdata = odl_pkg::ZERO_WORD;
                    next_readdata[odl_pkg::STAT_VALID] = sample_valid;
                    next_readdata[odl_pkg::STAT_STICKY] = sample_sticky;
                end
                odl_pkg::OFS_CAPTURE: next_readdata = capture;
                odl_pkg::OFS_RX_SEQ: next_readdata = 32'(lm_seq_field) << odl_pkg::RX_SEQ_LSB;
                odl_pkg::OFS_DM_SEQ: next_readdata = 32'(dm_latest);
                odl_pkg::OFS_HELD_RX: next_readdata = held_rx;
                odl_pkg::OFS_HELD_TXF: next_readdata = held_txf;
                default: next_readdata = odl_pkg::ZERO_WORD;
            endcase
        end

        // Register writes
        if (wr_take) begin
            unique case (avs_address_i)
                odl_pkg::OFS_CTRL: begin
                    wv = lane_merge(32'(ctrl), avs_writedata_i, avs_byteenable_i);
                    next_ctrl = wv[odl_pkg::CTRL_W-1:0];
                end
                odl_pkg::OFS_PERIOD: begin
                    wv = lane_merge(32'(period), avs_writedata_i, avs_byteenable_i);
                    next_period = wv[odl_pkg::PERIOD_W-1:0];
                end
                odl_pkg::OFS_STATUS: begin
                    if (avs_byteenable_i[0]) begin
                        if (avs_writedata_i[odl_pkg::STAT_VALID]) begin
                            next_sample_valid = 1'b0;
                        end
                        if (avs_writedata_i[odl_pkg::STAT_STICKY]) begin
                            next_sample_sticky = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Transmit of a continuity frame
        if (cc_tx_req_i.valid) begin
            next_cc_tx.valid = 1'b1;
            if (loss_cc_hw_enable) begin // R2
                if (!up_mep) begin
                    // Period counter paces counter-carrying frames
                    if (period != odl_pkg::PERIOD_RESET) begin
                        period_hit = (period_cnt + odl_pkg::PERIOD_ONE) >= period; // R4
                        next_period_cnt = period_hit ? odl_pkg::PERIOD_RESET
                            : period_cnt + odl_pkg::PERIOD_ONE; // R4
                    end
                    if (loss_insert_next || period_hit) begin
                        next_cc_tx.loss = 1'b1;
                        next_cc_tx.txfcf = tx_loss_counter_i; // R3
                        next_cc_tx.rxfcb = held_rx; // R3 R7
                        next_cc_tx.txfcb = held_txf; // R3 R7
                        next_ctrl[odl_pkg::CTRL_INS_NEXT] = 1'b0; // R3
                    end
                end else if (cc_tx_req_i.cpu_loss) begin
                    // Masqueraded frame: forward count only, no backward counters
                    next_cc_tx.loss = 1'b1;
                    next_cc_tx.txfcf = tx_loss_counter_i; // R8 R9
                end
            end
        end

        // Reception of a continuity frame at ingress
        cc_loss = cc_rx_i.valid && loss_cc_hw_enable && is_loss_frame(cc_rx_i); // R1 R2
        if (cc_loss && !up_mep) begin
            next_extract.valid = 1'b1;
            next_extract.value = rx_loss_counter_i; // R5
            next_pdu_upd.valid = pdu_local_rx_count_update_enable; // R6
            next_pdu_upd.value = rx_loss_counter_i; // R6
            next_held_rx = rx_loss_counter_i; // R7
            next_held_txf = cc_rx_i.txfcf; // R7
        end else if (cc_loss) begin
            next_lm_seq = lm_seq + odl_pkg::SEQ_ONE; // R10 R22
            next_extract.valid = 1'b1; // R10
            next_extract.value = 32'(lm_seq + odl_pkg::SEQ_ONE);
            next_egr_fwd = 1'b1; // R10
        end

        // Arrival of a forwarded loss frame at the egress engine
        if (cc_egress_i && loss_cc_hw_enable && up_mep) begin
            next_capture = rx_loss_counter_i; // R11
            next_lm_seq_field = lm_seq; // R11
            next_sample_valid = 1'b1; // R12
            if (sample_valid) begin
                next_sample_sticky = 1'b1; // R12
            end
        end

        // Reception of a delay PDU; loss frames take the extraction slot first
        dm_ok = dm_rx_i.valid && (dm_rx_i.kind != odl_pkg::ODL_DM_NONE)
            && ((dm_rx_i.kind != odl_pkg::ODL_DM_ONE_WAY) || one_way_delay_enable); // R16
        if (dm_ok && up_mep) begin
            next_dm_latest = dm_seq; // R14
            next_dm_seq = dm_seq + odl_pkg::SEQ_ONE; // R13 R14 R22
            if (!cc_loss) begin
                next_extract.valid = 1'b1; // R20
                next_extract.value = 32'(dm_seq) << odl_pkg::HDR_SEQ_LSB; // R13 R15
            end
        end else if (dm_ok && (dm_rx_i.kind == odl_pkg::ODL_DM_ONE_WAY)) begin
            if (front_port_cpu) begin
                next_pdu_upd.valid = 1'b1; // R18
                next_pdu_upd.value = time_now_i; // R18
            end else if (!cc_loss) begin
                next_extract.valid = 1'b1; // R18
                next_extract.value = time_now_i; // R18
            end
        end

        // Egress arrival of a delay PDU at the Up-MEP
        if (dm_egress_i.valid && up_mep && one_way_delay_enable) begin
            next_tsq.valid = 1'b1; // R21
            next_tsq.ts = time_now_i; // R21
            next_tsq.port = dm_egress_i.port; // R21
            next_tsq.engine = ENGINE_NUM; // R21
            next_tsq.seq = dm_egress_i.seq; // R21
        end

        // Transmit timestamp of an injected one-way delay frame
        if (dm_tx_req_i.valid && one_way_delay_enable) begin // R16
            next_dm_ts.valid = 1'b1;
            next_dm_ts.value = up_mep ? dm_tx_req_i.cpu_time : time_now_i; // R17 R19
        end
    end

    // ====================
    // State registers, frozen while the clock enable is low
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl <= odl_pkg::CTRL_RESET;
            period <= odl_pkg::PERIOD_RESET;
            period_cnt <= odl_pkg::PERIOD_RESET;
            sample_valid <= 1'b0;
            sample_sticky <= 1'b0;
            capture <= odl_pkg::ZERO_WORD;
            lm_seq <= '0;
            lm_seq_field <= '0;
            dm_seq <= '0;
            dm_latest <= '0;
            held_rx <= odl_pkg::ZERO_WORD;
            held_txf <= odl_pkg::ZERO_WORD;
            readdata <= odl_pkg::ZERO_WORD;
            waitreq <= 1'b1;
            cc_tx <= '0;
            extract <= '0;
            pdu_upd <= '0;
            dm_ts <= '0;
            tsq <= '0;
            egr_fwd <= 1'b0;
        end else if (clk_en_i) begin
            ctrl <= next_ctrl;
            period <= next_period;
            period_cnt <= next_period_cnt;
            sample_valid <= next_sample_valid;
            sample_sticky <= next_sample_sticky;
            capture <= next_capture;
            lm_seq <= next_lm_seq;
            lm_seq_field <= next_lm_seq_field;
            dm_seq <= next_dm_seq;
            dm_latest <= next_dm_latest;
            held_rx <= next_held_rx;
            held_txf <= next_held_txf;
            readdata <= next_readdata;
            waitreq <= next_waitreq;
            cc_tx <= next_cc_tx;
            extract <= next_extract;
            pdu_upd <= next_pdu_upd;
            dm_ts <= next_dm_ts;
            tsq <= next_tsq;
            egr_fwd <= next_egr_fwd;
        end
    end

    // ====================
    // Outputs straight from flops
    assign avs_readdata_o = readdata;
    assign avs_waitrequest_o = waitreq;
    assign cc_tx_o = cc_tx;
    assign extract_o = extract;
    assign pdu_update_o = pdu_upd;
    assign dm_tx_timestamp_o = dm_ts;
    assign tsq_write_o = tsq;
    assign egress_forward_o = egr_fwd;

endmodule : odl_engine

// ===== inc/odl_pkg.sv
/*
 * Shared constants and carrier types for the OAM endpoint loss and delay engine.
 * Assumes one switch core clock and an Avalon-MM master using byte addresses.
 */
package odl_pkg;

    // ====================
    // Register map (byte offsets)
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_PERIOD = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_CAPTURE = 5'h0c;
    localparam logic [4:0] OFS_RX_SEQ = 5'h10;
    localparam logic [4:0] OFS_DM_SEQ = 5'h14;
    localparam logic [4:0] OFS_HELD_RX = 5'h18;
    localparam logic [4:0] OFS_HELD_TXF = 5'h1c;

    // ====================
    // Control register fields
    localparam int unsigned CTRL_LOSS_EN = 0;
    localparam int unsigned CTRL_DELAY_EN = 1;
    localparam int unsigned CTRL_UP_MEP = 2;
    localparam int unsigned CTRL_PDU_UPD = 3;
    localparam int unsigned CTRL_FRONT_CPU = 4;
    localparam int unsigned CTRL_INS_NEXT = 5;
    localparam int unsigned CTRL_W = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Status register fields (write one to clear)
    localparam int unsigned STAT_VALID = 0;
    localparam int unsigned STAT_STICKY = 1;

    // Sequence fields
    localparam int unsigned SEQ_W = 5;
    localparam int unsigned RX_SEQ_LSB = 16;
    localparam int unsigned HDR_SEQ_LSB = 27;
    localparam int unsigned PERIOD_W = 8;
    localparam logic [7:0] PERIOD_RESET = 8'h00;
    localparam logic [4:0] SEQ_ONE = 5'h01;
    localparam logic [7:0] PERIOD_ONE = 8'h01;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // Delay PDU kinds
    typedef enum logic [1:0] {
        ODL_DM_NONE,
        ODL_DM_ONE_WAY,
        ODL_DM_REQUEST,
        ODL_DM_REPLY
    } odl_dm_kind_t;

    // ====================
    // Carriers (counter and timestamp width fixed at one bus word)
    typedef struct packed {
        logic valid;
        logic [31:0] txfcf;
        logic [31:0] rxfcb;
        logic [31:0] txfcb;
    } odl_cc_rx_t;

    typedef struct packed {
        logic valid;
        logic cpu_loss;
    } odl_cc_tx_req_t;

    typedef struct packed {
        logic valid;
        logic loss;
        logic [31:0] txfcf;
        logic [31:0] rxfcb;
        logic [31:0] txfcb;
    } odl_cc_tx_t;

    typedef struct packed {
        logic valid;
        odl_dm_kind_t kind;
    } odl_dm_rx_t;

    typedef struct packed {
        logic valid;
        logic [4:0] seq;
        logic [7:0] port;
    } odl_dm_egr_t;

    typedef struct packed {
        logic valid;
        logic [31:0] cpu_time;
    } odl_dm_tx_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] value;
    } odl_word_t;

    typedef struct packed {
        logic valid;
        logic [31:0] ts;
        logic [7:0] port;
        logic [7:0] engine;
        logic [4:0] seq;
    } odl_tsq_t;

endpackage : odl_pkg

// ===== sim/odl_assertions.sv
/* Port checker for the OAM loss and delay engine.
   Assumes bind to odl_engine, clk_en_i held high, one clock. */
module odl_assertions #(
    parameter logic [7:0] ENGINE_NUM = 8'h00
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [odl_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic [31:0] tx_loss_counter_i,
    input wire logic [31:0] time_now_i,
    input wire odl_pkg::odl_cc_rx_t cc_rx_i,
    input wire odl_pkg::odl_cc_tx_req_t cc_tx_req_i,
    input wire odl_pkg::odl_dm_rx_t dm_rx_i,
    input wire odl_pkg::odl_dm_egr_t dm_egress_i,
    input wire odl_pkg::odl_dm_tx_req_t dm_tx_req_i,
    input wire odl_pkg::odl_cc_tx_t cc_tx_o,
    input wire odl_pkg::odl_word_t extract_o,
    input wire odl_pkg::odl_word_t dm_tx_timestamp_o,
    input wire odl_pkg::odl_tsq_t tsq_write_o,
    input wire logic egress_forward_o
);
    // ====================
    // Bus handshake and frame event checks
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("request not answered next cycle");
    wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("wait low longer than one cycle");
    unmapped_read_a: assert property (avs_read_i && !avs_waitrequest_o
        && avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
    zero_frame_a: assert property (
        (!cc_rx_i.valid || {cc_rx_i.txfcf, cc_rx_i.rxfcb, cc_rx_i.txfcb} == 96'h0)
        && !dm_rx_i.valid |=> !extract_o.valid) else $error("extract without loss frame");
    tx_count_a: assert property (cc_tx_o.valid && cc_tx_o.loss
        |-> cc_tx_o.txfcf == $past(tx_loss_counter_i)) else $error("wrong forward count");
    tx_cause_a: assert property (!cc_tx_req_i.valid |=> !cc_tx_o.valid)
        else $error("frame out without request");
    fwd_cause_a: assert property (!cc_rx_i.valid |=> !egress_forward_o)
        else $error("forward without ingress frame");
    ts_cause_a: assert property (!dm_tx_req_i.valid |=> !dm_tx_timestamp_o.valid)
        else $error("timestamp without request");
    tsq_entry_a: assert property (tsq_write_o.valid |-> $past(dm_egress_i.valid)
        && tsq_write_o.seq == $past(dm_egress_i.seq)
        && tsq_write_o.port == $past(dm_egress_i.port)
        && tsq_write_o.ts == $past(time_now_i) && tsq_write_o.engine == ENGINE_NUM)
        else $error("bad timestamp queue entry");

    // Main scenarios reached
    extract_c: cover property (extract_o.valid);
    loss_tx_c: cover property (cc_tx_o.valid && cc_tx_o.loss);
    tsq_c: cover property (tsq_write_o.valid);
endmodule : odl_assertions

// ===== sim/odl_peer.sv
/* Peer endpoint model: sends continuity frames carrying loss counters.
   Assumes the bench raises send_i for one cycle per frame. */
module odl_peer (
    input wire logic core_clk_i,
    input wire logic send_i,
    input wire odl_pkg::odl_cc_rx_t frame_i,
    output odl_pkg::odl_cc_rx_t cc_rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [95:0] last = '0;

    // Last counters sent; inverted each idle cycle, so stale data reappears every second idle cycle
    always @(posedge core_clk_i) begin
        if (send_i) begin
            last <= {frame_i.txfcf, frame_i.rxfcb, frame_i.txfcb};
        end else begin
            last <= ~last;
        end
    end

    // Counter fields are only qualified by the frame strobe
    assign cc_rx_o = send_i ? {1'b1, frame_i.txfcf, frame_i.rxfcb, frame_i.txfcb}
        : {1'b0, ~last};
endmodule : odl_peer

// ===== sim/tb_top.sv
/* Self-checking bench for the OAM loss and delay engine.
   Assumes odl_pkg, odl_engine, odl_peer and odl_assertions compiled first. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] rv;
    logic waitreq;
    logic [31:0] tx_cnt = 32'h0;
    logic [31:0] rx_cnt = 32'h0;
    logic [31:0] tnow = 32'h0;
    logic send = 1'b0;
    logic cc_egr = 1'b0;
    logic fwd;
    odl_pkg::odl_cc_rx_t frame = '0;
    odl_pkg::odl_cc_rx_t cc_rx;
    odl_pkg::odl_cc_tx_req_t tx_req = '0;
    odl_pkg::odl_dm_rx_t dm_rx = '0;
    odl_pkg::odl_dm_egr_t dm_egr = '0;
    odl_pkg::odl_dm_tx_req_t dm_req = '0;
    odl_pkg::odl_cc_tx_t cc_tx;
    odl_pkg::odl_word_t ext;
    odl_pkg::odl_word_t upd;
    odl_pkg::odl_word_t dm_ts;
    odl_pkg::odl_tsq_t tsq;
    int err_total = 0;
    int tests_run = 0;
    int seed = 49;
    int i;
    int n;
    logic [31:0] r;
    logic [31:0] hrx;
    logic [31:0] htx;

    // ====================
    // Clock, design and peer
    always #20 clk = ~clk;

    odl_engine odl_engine_inst (.core_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(1'b1),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .tx_loss_counter_i(tx_cnt), .rx_loss_counter_i(rx_cnt), .time_now_i(tnow),
        .cc_rx_i(cc_rx), .cc_egress_i(cc_egr), .cc_tx_req_i(tx_req), .dm_rx_i(dm_rx),
        .dm_egress_i(dm_egr), .dm_tx_req_i(dm_req), .cc_tx_o(cc_tx), .extract_o(ext),
        .pdu_update_o(upd), .dm_tx_timestamp_o(dm_ts), .tsq_write_o(tsq), .egress_forward_o(fwd));

    odl_peer odl_peer_inst (.core_clk_i(clk), .send_i(send), .frame_i(frame), .cc_rx_o(cc_rx));

    // ====================
    // Tasks
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk

    // One bus cycle, held until wait is sampled low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        if (k == 20) begin
            err_total++;
            give_verdict();
        end
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rv, exp);
    endtask : rdc

    // New random counters and time at the event edge
    task automatic rnd;
        tx_cnt <= $random(seed);
        rx_cnt <= $random(seed);
        tnow <= $random(seed);
        r = $random(seed);
    endtask : rnd

    // Event taken at next edge, outputs looked at one edge later
    task automatic tick;
        @(posedge clk);
        send <= 1'b0;
        cc_egr <= 1'b0;
        tx_req.valid <= 1'b0;
        dm_rx.valid <= 1'b0;
        dm_egr.valid <= 1'b0;
        dm_req.valid <= 1'b0;
        @(posedge clk);
    endtask : tick

    task automatic cc(input logic [31:0] f, input logic [31:0] b, input logic [31:0] c);
        rnd();
        frame <= {1'b1, f, b, c};
        send <= 1'b1;
        tick();
    endtask : cc

    task automatic txf(input logic cl);
        rnd();
        tx_req <= {1'b1, cl};
        tick();
    endtask : txf

    task automatic dmt;
        rnd();
        dm_req <= {1'b1, r};
        tick();
    endtask : dmt

    task automatic dmr(input odl_pkg::odl_dm_kind_t kd);
        rnd();
        dm_rx <= {1'b1, kd};
        tick();
    endtask : dmr

    // ====================
    // Main sequence and hang guard
    initial begin
        #2000000;
        err_total++;
        give_verdict();
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (i = 0; i < 8; i++) rdc(5'(i * 4), 32'h0);
        rdc(5'h02, 32'h0);
        bus(1'b1, odl_pkg::OFS_HELD_RX, 32'hffff_ffff);
        rdc(odl_pkg::OFS_HELD_RX, 32'h0);
        cc(32'h1, 32'h0, 32'h0);
        chk(32'(ext.valid), 32'h0);
        bus(1'b1, odl_pkg::OFS_CTRL, 32'h09);
        for (i = 0; i < 3; i++) begin
            r = $random(seed) | 32'h1;
            htx = r;
            cc(i == 2 ? htx : 32'h0, i == 1 ? htx : 32'h0, i == 0 ? htx : 32'h0);
            chk(32'({ext.valid, upd.valid}), 32'h3);
            chk(ext.value, rx_cnt);
            chk(upd.value, rx_cnt);
        end
        hrx = rx_cnt;
        cc(32'h0, 32'h0, 32'h0);
        chk(32'(ext.valid), 32'h0);
        rdc(odl_pkg::OFS_HELD_RX, hrx);
        rdc(odl_pkg::OFS_HELD_TXF, htx);
        bus(1'b1, odl_pkg::OFS_CTRL, 32'h21);
        txf(1'b0);
        chk(32'({cc_tx.valid, cc_tx.loss}), 32'h3);
        chk(cc_tx.txfcf, tx_cnt);
        chk(cc_tx.rxfcb, hrx);
        chk(cc_tx.txfcb, htx);
        rdc(odl_pkg::OFS_CTRL, 32'h01);
        txf(1'b0);
        chk(32'({cc_tx.valid, cc_tx.loss}), 32'h2);
        bus(1'b1, odl_pkg::OFS_PERIOD, 32'h02);
        n = 0;
        for (i = 0; i < 4; i++) begin
            txf(1'b0);
            n += int'(cc_tx.loss);
        end
        chk(32'(n), 32'h2);
        bus(1'b1, odl_pkg::OFS_PERIOD, 32'h0);
        bus(1'b1, odl_pkg::OFS_CTRL, 32'h07);
        txf(1'b1);
        chk(cc_tx.txfcf, tx_cnt);
        cc(32'h5, 32'h0, 32'h0);
        chk(32'({ext.valid, fwd}), 32'h3);
        for (i = 0; i < 2; i++) begin
            rnd();
            cc_egr <= 1'b1;
            tick();
            rdc(odl_pkg::OFS_CAPTURE, rx_cnt);
            rdc(odl_pkg::OFS_STATUS, 32'(i * 2 + 1));
        end
        rdc(odl_pkg::OFS_RX_SEQ, 32'h0001_0000);
        bus(1'b1, odl_pkg::OFS_STATUS, 32'h3);
        rdc(odl_pkg::OFS_STATUS, 32'h0);
        for (i = 0; i < 34; i++) begin
            dmr(odl_pkg::odl_dm_kind_t'(2'(i % 3 + 1)));
            chk(ext.value, {i[4:0], 27'h0});
        end
        rdc(odl_pkg::OFS_DM_SEQ, 32'h1);
        rnd();
        dm_egr <= {1'b1, 5'h1f, 8'h03};
        tick();
        chk(tsq.ts, tnow);
        chk(32'({tsq.engine, tsq.port, tsq.seq}), 32'(21'h00_007f));
        dmt();
        chk(dm_ts.value, r);
        bus(1'b1, odl_pkg::OFS_CTRL, 32'h02);
        dmt();
        chk(dm_ts.value, tnow);
        dmr(odl_pkg::ODL_DM_ONE_WAY);
        chk(ext.value, tnow);
        bus(1'b1, odl_pkg::OFS_CTRL, 32'h12);
        dmr(odl_pkg::ODL_DM_ONE_WAY);
        chk(upd.value, tnow);
        bus(1'b1, odl_pkg::OFS_CTRL, 32'h0);
        dmt();
        chk(32'(dm_ts.valid), 32'h0);
        give_verdict();
    end
endmodule : tb_top

bind odl_engine odl_assertions #(.ENGINE_NUM(ENGINE_NUM)) odl_assertions_inst (.*);
